// *** core/otf_device.sv ***
/* Module end of the out-of-band link: forward deserialiser and tunnel
   frame parser on fwdClk, reverse symbol sender on revClk, user side on
   clock. Assumes the host runs both link clocks freely.
// Operation
// R1 - Forward rates 1.544/3.088 or 2.048 Mbps
// R2 - Reverse rates 772/1544 or 128 ksymbol/s
// R3 - Host sends forward bits with bit clock
// R4 - Reverse uses I, Q, symbol clock, enable
// R5 - Host sources the link clocks
// R6 - Tunnel and both legacy methods supported
// R7 - Exactly one method active at once
// R8 - Legacy mode: module runs link layers
// R9 - Tunnel mode bypasses legacy link processing
// R10 - Tunnel upstream goes via modem, not reverse
// R11 - Host caps tunnel rate at 2.048 Mbps
// R12 - Frame starts with two-byte following count
// R13 - No CRC on frames crossing link
// R14 - Invalid tunnel frames are discarded
// R15 - Host buffers two tunnel PDUs
// R16 - Host strips trailing modem CRC
// R17 - Host strips configured leading header bytes
// R18 - Strip exact count regardless of headers
// R19 - Module chooses the strip count
// R20 - Length MSB first, payload follows gaplessly
*/
`timescale 1ns/1ps
`default_nettype none
`include "otf_regs.svh"
module otf_device (
	otf_link_if.dev link,
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic ce,
	input wire otf_pkg::otf_method_t cfgMethod,
	input wire otf_pkg::otf_byte_t cfgStrip,
	output logic rxValid,
	output otf_pkg::otf_byte_t rxData,
	output logic rxEnd,
	output logic rxBad,
	input wire logic txI,
	input wire logic txQ,
	input wire logic txValid,
	output logic txReady
);
	import otf_pkg::*;

	// User-domain state.
	otf_method_t methodQ; // Active method.
	otf_byte_t stripQ; // Strip count shown to the host.
	logic frameOpenQ; // A tunnel frame is being delivered.
	logic [2:0] fSyncQ; // Forward event toggle synchroniser.
	logic txReqQ; // Reverse request toggle.
	logic [1:0] txSymQ; // Reverse symbol held for the crossing.
	logic [1:0] aSyncQ; // Reverse acknowledge synchroniser.
	logic txIdle; // No reverse symbol outstanding.
	logic fEvt; // A forward event has crossed.

	// Forward-domain state.
	otf_method_t fMth1Q; // Method synchroniser, first stage.
	otf_method_t fMthQ; // Method as seen on the forward side.
	otf_byte_t shiftQ; // Bit collector.
	logic [2:0] bitCntQ; // Bits of the current byte.
	logic inFrameQ; // Bits arrived since fwdValid rose.
	logic [1:0] hdrCntQ; // Length bytes taken so far.
	otf_byte_t lenHiQ; // Upper length byte.
	otf_len_t remQ; // Payload bytes still due.
	logic overQ; // Frame ran past its count.
	logic fEvtQ; // Forward event toggle.
	logic [9:0] fWordQ; // Event word: end, bad, byte.
	otf_byte_t fByte; // Byte completed by this bit.
	logic fByteDone; // This bit closes a byte.
	logic fTunnel; // Forward side is in tunnel mode.
	logic fBad; // Frame fails its checks.
	logic fPost; // Post an event this edge.
	logic [9:0] fWord; // Word to post.

	// Reverse-domain state.
	logic [2:0] rSyncQ; // Request toggle synchroniser.
	logic ackQ; // Acknowledge toggle.

	assign link.method = methodQ;
	assign link.stripCount = stripQ;
	assign txIdle = (aSyncQ[1] == txReqQ);
	assign fEvt = fSyncQ[2] ^ fSyncQ[1];
	// Symbols are refused in tunnel mode; upstream then leaves via the modem.
	assign txReady = txIdle && (methodQ != MTH_TUNNEL); // [R10]

	// Method and strip count change only with no tunnel payload open on the user side and no
	// reverse symbol outstanding; a legacy byte or a tunnel length prefix on the wire is not guarded.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			methodQ <= MTH_LEGACY_A;
			stripQ <= `OTF_STRIP_RST;
		end else if (ce && !frameOpenQ && txIdle) begin
			methodQ <= cfgMethod; // [R6] [R7]
			stripQ <= cfgStrip; // [R19]
		end
	end

	// Carry the method onto the forward clock as a quasi-static level.
	always_ff @(posedge link.fwdClk or posedge sys_rst) begin
		if (sys_rst) begin
			fMth1Q <= MTH_LEGACY_A;
			fMthQ <= MTH_LEGACY_A;
		end else begin
			fMth1Q <= methodQ;
			fMthQ <= fMth1Q;
		end
	end

	assign fTunnel = (fMthQ == MTH_TUNNEL);
	// Bits arrive MSB first; the byte closes on its eighth bit.
	assign fByte = {shiftQ[6:0], link.fwdData}; // [R20]
	assign fByteDone = link.fwdValid && (bitCntQ == 3'h7); // [R1] [R3]
	// A frame is bad if it overran, fell short or ended mid-byte.
	assign fBad = overQ || (remQ != '0) || (hdrCntQ != 2'h2)
		|| (bitCntQ != 3'h0); // [R14]

	// Forward collector and tunnel length parser. No CRC is looked
	// for: the count alone delimits the frame.
	always_ff @(posedge link.fwdClk or posedge sys_rst) begin
		if (sys_rst) begin
			shiftQ <= 8'h00;
			bitCntQ <= 3'h0;
			inFrameQ <= 1'b0;
			hdrCntQ <= 2'h0;
			lenHiQ <= 8'h00;
			remQ <= '0;
			overQ <= 1'b0;
		end else if (link.fwdValid) begin
			shiftQ <= fByte;
			bitCntQ <= bitCntQ + 3'h1;
			inFrameQ <= 1'b1;
			if (fByteDone && fTunnel) begin // [R9] [R13]
				if (hdrCntQ == 2'h0) begin
					// High byte of the count comes first.
					lenHiQ <= fByte; // [R12] [R20]
					hdrCntQ <= 2'h1;
				end else if (hdrCntQ == 2'h1) begin
					remQ <= {lenHiQ, fByte}; // [R12]
					hdrCntQ <= 2'h2;
				end else if (remQ == '0) begin
					// Extra bytes are dropped and spoil the frame.
					overQ <= 1'b1; // [R14]
				end else begin
					remQ <= remQ - otf_len_t'(1);
				end
			end
		end else begin
			// fwdValid low closes any frame and realigns bytes.
			bitCntQ <= 3'h0;
			inFrameQ <= 1'b0;
			hdrCntQ <= 2'h0;
			remQ <= '0;
			overQ <= 1'b0;
		end
	end

	// Choose what crosses: every legacy byte, tunnel payload bytes
	// within the count, and one end marker per tunnel frame.
	always_comb begin
		fPost = 1'b0;
		fWord = {2'b00, fByte};
		if (fByteDone) begin
			if (!fTunnel) begin
				fPost = 1'b1; // [R8]
			end else if (hdrCntQ == 2'h2 && remQ != '0) begin
				fPost = 1'b1; // [R9]
			end
		end else if (!link.fwdValid && inFrameQ && fTunnel) begin
			fPost = 1'b1;
			fWord = {1'b1, fBad, 8'h00}; // [R14]
		end
	end

	// Forward event register: the word holds until the next toggle,
	// long after the user side has sampled it.
	always_ff @(posedge link.fwdClk or posedge sys_rst) begin
		if (sys_rst) begin
			fEvtQ <= 1'b0;
			fWordQ <= 10'h000;
		end else if (fPost) begin
			fEvtQ <= ~fEvtQ;
			fWordQ <= fWord;
		end
	end

	// Toggle synchroniser; only stage 1 reads stage 0.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			fSyncQ <= 3'h0;
		end else if (ce) begin
			fSyncQ <= {fSyncQ[1:0], fEvtQ};
		end
	end

	// User-side delivery. A bad frame is only flagged at its end:
	// with no buffer, its bytes have already gone out.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			rxValid <= 1'b0;
			rxEnd <= 1'b0;
			rxBad <= 1'b0;
			rxData <= 8'h00;
			frameOpenQ <= 1'b0;
		end else if (ce) begin
			rxValid <= 1'b0;
			rxEnd <= 1'b0;
			if (fEvt && fWordQ[9]) begin
				rxEnd <= 1'b1;
				rxBad <= fWordQ[8]; // [R14]
				frameOpenQ <= 1'b0;
			end else if (fEvt) begin
				rxValid <= 1'b1;
				rxData <= fWordQ[7:0];
				frameOpenQ <= (methodQ == MTH_TUNNEL);
			end
		end
	end

	// Reverse request: one symbol at a time crosses by toggle.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			txReqQ <= 1'b0;
			txSymQ <= 2'b00;
		end else if (ce && txValid && txReady) begin
			txReqQ <= ~txReqQ;
			txSymQ <= {txI, txQ}; // [R4]
		end
	end

	// Acknowledge synchroniser back into the user domain.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			aSyncQ <= 2'b00;
		end else if (ce) begin
			aSyncQ <= {aSyncQ[0], ackQ};
		end
	end

	// Reverse sender: one symbol per revClk with the enable raised;
	// the enable drops whenever no symbol is waiting.
	always_ff @(posedge link.revClk or posedge sys_rst) begin
		if (sys_rst) begin
			rSyncQ <= 3'h0;
			ackQ <= 1'b0;
			link.revI <= 1'b0;
			link.revQ <= 1'b0;
			link.revEn <= 1'b0;
		end else begin
			rSyncQ <= {rSyncQ[1:0], txReqQ};
			if (rSyncQ[2] ^ rSyncQ[1]) begin
				link.revI <= txSymQ[1]; // [R2] [R4]
				link.revQ <= txSymQ[0];
				link.revEn <= 1'b1; // [R8]
				ackQ <= ~ackQ;
			end else begin
				link.revEn <= 1'b0;
			end
		end
	end
endmodule // otf_device
`default_nettype wire

// *** core/otf_regs.svh ***
/* Constants for the out-of-band tunnel link: rates, dividers, framing.
   Assumes a 10 MHz core clock on the host end. */
`ifndef OTF_REGS_SVH
`define OTF_REGS_SVH
// Core clock rate in hertz.
`define OTF_CLK_HZ 10000000
// Ceiling on the tunnel bit rate toward the module, bits per second.
`define OTF_TUNNEL_BPS 2048000
// Fastest legacy reverse symbol rate, symbols per second.
`define OTF_REV_SYM_HZ 1544000
// Dividers round up, so no link rate ever exceeds its ceiling.
`define OTF_FWD_DIV ((`OTF_CLK_HZ + `OTF_TUNNEL_BPS - 1) / `OTF_TUNNEL_BPS)
`define OTF_REV_DIV ((`OTF_CLK_HZ + `OTF_REV_SYM_HZ - 1) / `OTF_REV_SYM_HZ)
// Bytes in the length prefix and in the trailing modem CRC.
`define OTF_LEN_BYTES 2
`define OTF_CRC_BYTES 4
// Reset value of the header strip count.
`define OTF_STRIP_RST 8'h00
// Tunnel buffer depth per bank, in bytes.
`define OTF_BUF_DEPTH 2048
`endif

// *** core/otf_pkg.sv ***
/* Types shared by both ends of the out-of-band tunnel link.
   Assumes otf_regs.svh is on the include path. */
`default_nettype none
package otf_pkg;
`include "otf_regs.svh"
	// Out-of-band method; exactly one is active at a time.
	typedef enum logic [1:0] {MTH_TUNNEL, MTH_LEGACY_A, MTH_LEGACY_B} otf_method_t;
	// Length prefix word.
	typedef logic [8*`OTF_LEN_BYTES-1:0] otf_len_t;
	// One byte.
	typedef logic [7:0] otf_byte_t;
endpackage
`default_nettype wire

// *** core/otf_link_if.sv ***
/* Link between host and module: forward bit stream, reverse I/Q symbols,
   and the module's method and strip-count levels. Assumes otf_pkg. */
`timescale 1ns/1ps
`default_nettype none
interface otf_link_if;
	import otf_pkg::*;
	logic fwdClk; // Forward bit clock, made by the host.
	logic fwdData; // Forward serial data, valid at fwdClk rise.
	logic fwdValid; // Qualifies each forward bit; frames are its runs.
	logic revClk; // Reverse symbol clock, made by the host.
	logic revI; // Reverse I symbol bit.
	logic revQ; // Reverse Q symbol bit.
	logic revEn; // Reverse transmit enable.
	otf_method_t method; // Method chosen by the module.
	otf_byte_t stripCount; // Header bytes the host must strip.
	modport host (output fwdClk, fwdData, fwdValid, revClk,
		input revI, revQ, revEn, method, stripCount);
	modport dev (input fwdClk, fwdData, fwdValid, revClk,
		output revI, revQ, revEn, method, stripCount);
endinterface
`default_nettype wire

// *** core/otf_host.sv ***
/* Host end of the out-of-band link: makes both link clocks by dividing
   its own clock, frames tunnel packets from the modem into two banks,
   and samples reverse symbols. Assumes modem bytes end with a CRC. */
`timescale 1ns/1ps
`default_nettype none
`include "otf_regs.svh"
module otf_host #(
	parameter int FWD_DIV = `OTF_FWD_DIV,
	parameter int REV_DIV = `OTF_REV_DIV,
	parameter int DEPTH = `OTF_BUF_DEPTH
) (
	otf_link_if.host link,
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic legBit,
	input wire logic legBitValid,
	output logic legBitReady,
	input wire otf_pkg::otf_byte_t pktData,
	input wire logic pktValid,
	input wire logic pktLast,
	output logic pktReady,
	output logic symI,
	output logic symQ,
	output logic symValid
);
	import otf_pkg::*;
	localparam int AW = $clog2(DEPTH);
	localparam logic [7:0] FLAST = 8'(FWD_DIV - 1);
	localparam logic [7:0] FHALF = 8'(FWD_DIV / 2);
	localparam logic [7:0] RLAST = 8'(REV_DIV - 1);
	localparam logic [7:0] RHALF = 8'(REV_DIV / 2);
	typedef enum {SND_IDLE, SND_BUSY} otf_snd_t;

	logic [7:0] fCntQ, rCntQ; // Clock dividers.
	logic [7:0] fNext, rNext; // Next divider counts.
	logic fClkQ, rClkQ; // Divided clocks.
	logic fTick, rTick; // Last core cycle of each link period.
	otf_method_t mS1Q, mSQ; // Method synchroniser.
	otf_byte_t sS1Q, sSQ; // Strip count synchroniser.
	logic [2:0] vS1Q, vSQ; // Reverse pin synchroniser.
	logic [7:0] memQ [2][DEPTH]; // Two PDU banks.
	logic [AW:0] lenQ [2]; // Stored byte count per bank.
	logic [1:0] fullQ; // Bank holds a whole packet.
	logic wrBankQ, rdBankQ; // Bank being filled and being sent.
	logic [AW:0] wrPtrQ; // Fill position.
	otf_snd_t sndQ; // Sender state.
	logic [15:0] shQ; // Output shifter.
	logic [4:0] cntQ; // Bits left in shifter.
	logic [AW:0] idxQ, endQ; // Payload read position and end.
	logic [AW:0] tot, cut; // Stored length and bytes to remove.
	logic tunnel, shortPkt, start, rdDone; // Sender decisions.

	assign fNext = (fCntQ == FLAST) ? 8'h00 : fCntQ + 8'h01;
	assign rNext = (rCntQ == RLAST) ? 8'h00 : rCntQ + 8'h01;
	assign fTick = ce && (fCntQ == FLAST);
	assign rTick = ce && (rCntQ == RLAST);
	assign link.fwdClk = fClkQ;
	assign link.revClk = rClkQ;

	// Both link clocks are sourced here; forward data changes as
	// fwdClk falls, so it is stable at the module's rising edge.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			fCntQ <= 8'h00;
			rCntQ <= 8'h00;
			fClkQ <= 1'b0;
			rClkQ <= 1'b0;
		end else if (ce) begin
			fCntQ <= fNext; // [R5] [R1] [R11]
			rCntQ <= rNext; // [R2]
			fClkQ <= (fNext >= FHALF);
			rClkQ <= (rNext >= RHALF);
		end
	end

	// Two-stage synchronisers for everything the module drives.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			mS1Q <= MTH_LEGACY_A;
			mSQ <= MTH_LEGACY_A;
			sS1Q <= `OTF_STRIP_RST;
			sSQ <= `OTF_STRIP_RST;
			vS1Q <= 3'h0;
			vSQ <= 3'h0;
		end else if (ce) begin
			mS1Q <= link.method;
			mSQ <= mS1Q;
			sS1Q <= link.stripCount;
			sSQ <= sS1Q;
			vS1Q <= {link.revEn, link.revI, link.revQ};
			vSQ <= vS1Q;
		end
	end

	// Reverse symbols are taken as the symbol clock falls, at the end of its period,
	// well after the synchronised pins have settled.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			symI <= 1'b0;
			symQ <= 1'b0;
			symValid <= 1'b0;
		end else if (ce) begin
			symValid <= rTick && vSQ[2]; // [R4]
			if (rTick && vSQ[2]) begin
				symI <= vSQ[1];
				symQ <= vSQ[0];
			end
		end
	end

	assign tunnel = (mSQ == MTH_TUNNEL);
	assign tot = lenQ[rdBankQ];
	// CRC and the configured header count are removed blindly.
	assign cut = (AW+1)'(`OTF_CRC_BYTES) + (AW+1)'(sSQ); // [R16] [R17] [R18]
	assign shortPkt = (tot < cut);
	assign start = fTick && sndQ == SND_IDLE && tunnel && fullQ[rdBankQ];
	assign rdDone = (start && shortPkt) || (fTick && sndQ == SND_BUSY
		&& cntQ == 5'h00 && idxQ == endQ);
	assign pktReady = tunnel && !fullQ[wrBankQ]; // [R15]
	assign legBitReady = fTick && sndQ == SND_IDLE && !tunnel; // [R3]

	// Bank storage; memory needs no reset.
	always_ff @(posedge clock) begin
		if (ce && pktValid && pktReady) begin
			memQ[wrBankQ][wrPtrQ[AW-1:0]] <= pktData;
		end
	end

	// Bank bookkeeping: one bank fills while the other is sent. A full
	// bank set in the same cycle wins over the sender's clear of that bank.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			fullQ <= 2'b00;
			wrBankQ <= 1'b0;
			rdBankQ <= 1'b0;
			wrPtrQ <= '0;
			lenQ[0] <= '0;
			lenQ[1] <= '0;
		end else if (ce) begin
			if (rdDone) begin
				fullQ[rdBankQ] <= 1'b0;
				rdBankQ <= ~rdBankQ;
			end
			if (pktValid && pktReady && pktLast) begin
				fullQ[wrBankQ] <= 1'b1; // [R15]
				lenQ[wrBankQ] <= wrPtrQ + (AW+1)'(1);
				wrBankQ <= ~wrBankQ;
				wrPtrQ <= '0;
			end else if (pktValid && pktReady && wrPtrQ < (AW+1)'(DEPTH - 1)) begin
				// Oversized packets keep overwriting their last byte.
				wrPtrQ <= wrPtrQ + (AW+1)'(1);
			end
		end
	end

	// Forward sender: legacy bits pass straight through; a tunnel
	// packet goes out as a 16-bit count, MSB first, then its payload.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			sndQ <= SND_IDLE;
			shQ <= 16'h0000;
			cntQ <= 5'h00;
			idxQ <= '0;
			endQ <= '0;
			link.fwdData <= 1'b0;
			link.fwdValid <= 1'b0;
		end else if (fTick) begin
			unique case (sndQ)
				SND_IDLE: begin
					link.fwdValid <= legBitReady && legBitValid;
					link.fwdData <= legBit;
					if (start && !shortPkt) begin
						shQ <= otf_len_t'(tot - cut); // [R12]
						cntQ <= 5'(8 * `OTF_LEN_BYTES);
						idxQ <= (AW+1)'(sSQ); // [R17]
						endQ <= tot - (AW+1)'(`OTF_CRC_BYTES); // [R16] [R13]
						sndQ <= SND_BUSY;
					end
				end
				SND_BUSY: begin
					if (cntQ != 5'h00) begin
						link.fwdData <= shQ[15]; // [R20]
						link.fwdValid <= 1'b1;
						shQ <= {shQ[14:0], 1'b0};
						cntQ <= cntQ - 5'h01;
					end else if (idxQ != endQ) begin
						// Next byte follows with no idle bit between.
						link.fwdData <= memQ[rdBankQ][idxQ[AW-1:0]][7];
						link.fwdValid <= 1'b1;
						shQ <= {memQ[rdBankQ][idxQ[AW-1:0]][6:0], 9'h000};
						cntQ <= 5'h07;
						idxQ <= idxQ + (AW+1)'(1);
					end else begin
						link.fwdValid <= 1'b0;
						sndQ <= SND_IDLE;
					end
				end
			endcase
		end
	end
endmodule // otf_host
`default_nettype wire

// *** tb/otf_link_chk.sv ***
/* Checker for the link wires between the host and module ends.
   Assumes it sits beside the link interface, fed by its signals. */
`timescale 1ns/1ps
`default_nettype none
module otf_link_chk (
	input wire logic sys_rst,
	input wire logic fwdClk,
	input wire logic fwdData,
	input wire logic fwdValid,
	input wire logic revClk,
	input wire logic revI,
	input wire logic revQ,
	input wire logic revEn,
	input wire otf_pkg::otf_method_t method,
	input wire otf_pkg::otf_byte_t stripCount
);
	import otf_pkg::*;
	logic [19:0] bitCnt_q; // Qualified bits seen in the current run.
	otf_len_t lenSh_q; // First sixteen bits of a run, the length prefix.
	// Counts the bits of each run; a low fwdValid closes the run.
	always_ff @(posedge fwdClk or posedge sys_rst) begin
		if (sys_rst) begin
			bitCnt_q <= 20'h0;
		end else if (fwdValid) begin
			bitCnt_q <= bitCnt_q + 20'h1;
		end else begin
			bitCnt_q <= 20'h0;
		end
	end
	// Shifts in the prefix; later bits are payload and left alone.
	always_ff @(posedge fwdClk or posedge sys_rst) begin
		if (sys_rst) begin
			lenSh_q <= 16'h0;
		end else if (fwdValid && bitCnt_q < 20'h10) begin
			lenSh_q <= {lenSh_q[14:0], fwdData};
		end
	end
	// A tunnel run has just closed, with its count still held.
	sequence s_runEnd;
		method == MTH_TUNNEL && !fwdValid && bitCnt_q != 20'h0;
	endsequence
	// A symbol period followed by the idle period after it.
	sequence s_symbol;
		revEn ##1 !revEn;
	endsequence
	a_frame_length: assert property (
		@(posedge fwdClk) disable iff (sys_rst)
		s_runEnd |-> bitCnt_q == {1'b0, lenSh_q, 3'h0} + 20'h10)
		else $error("tunnel run length differs from its prefix");
	a_frame_gap: assert property (
		@(posedge fwdClk) disable iff (sys_rst)
		s_runEnd |=> !fwdValid)
		else $error("tunnel frames closer than two bit gaps");
	a_method_legal: assert property (
		@(posedge revClk) disable iff (sys_rst)
		method inside {MTH_TUNNEL, MTH_LEGACY_A, MTH_LEGACY_B})
		else $error("method code outside the three methods");
	a_method_steady: assert property (
		@(posedge fwdClk) disable iff (sys_rst)
		method == MTH_TUNNEL && fwdValid && $past(fwdValid)
		|-> $stable(method))
		else $error("method changed inside a tunnel frame");
	a_strip_steady: assert property (
		@(posedge fwdClk) disable iff (sys_rst)
		method == MTH_TUNNEL && fwdValid && $past(fwdValid)
		|-> $stable(stripCount))
		else $error("strip count changed inside a tunnel frame");
	a_rev_quiet: assert property (
		@(posedge revClk) disable iff (sys_rst)
		method == MTH_TUNNEL && $past(method) == MTH_TUNNEL |-> !revEn)
		else $error("reverse enable raised in tunnel mode");
	a_rev_one_period: assert property (
		@(posedge revClk) disable iff (sys_rst)
		$rose(revEn) |=> !revEn)
		else $error("reverse enable longer than one symbol");
	a_rev_sym_hold: assert property (
		@(posedge revClk) disable iff (sys_rst)
		s_symbol |-> $stable({revI, revQ}))
		else $error("symbol bits moved after their period");
endmodule // otf_link_chk
`default_nettype wire

// *** tb/otf_tb_top.sv ***
/* Testbench joining host and module ends over one link interface.
   Assumes the design files and otf_link_chk are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module out_of_band_tunnel_frame_port_tb_top;
	import otf_pkg::*;
	logic clock = 1'b0; // Core clock, 100 ns period.
	// Starts low and is raised just after time zero, so that every
	// asynchronous reset, the link-clock domains included, sees a real
	// rising edge; a value given at declaration makes no edge at all.
	logic sys_rst = 1'b0;
	logic ce = 1'b1; // Clock enable shared by both ends.
	otf_method_t cfgMethod = MTH_LEGACY_A; // Method the module adopts.
	otf_byte_t cfgStrip = 8'h00; // Header bytes the host removes.
	logic legBit = 1'b0, legBitValid = 1'b0, legBitReady;
	otf_byte_t pktData = 8'h00, rxData;
	logic pktValid = 1'b0, pktLast = 1'b0, pktReady;
	logic symI, symQ, symValid, rxValid, rxEnd, rxBad, txReady;
	logic txI = 1'b0, txQ = 1'b0, txValid = 1'b0;
	int mismatches = 0;
	int checks = 0;
	int endCnt = 0; // Frame ends seen on the user side.
	logic lastBad = 1'b0; // Discard flag of the latest frame end.
	otf_byte_t rxQ[$]; // Bytes delivered by the module.
	logic fwdBits[$]; // Qualified bits seen on the forward wire.
	otf_method_t legM[2] = '{MTH_LEGACY_A, MTH_LEGACY_B};
	int tStrip[4] = '{0, 3, 3, 3};
	int tLen[4] = '{9, 12, 7, 6}; // Last one is too short and dropped.
	otf_len_t w;
	always #50 clock = ~clock;
	otf_link_if otf_link_if_i();
	otf_host #(.FWD_DIV(5), .REV_DIV(7), .DEPTH(64)) otf_host_i (
		.link(otf_link_if_i), .clock(clock), .sys_rst(sys_rst), .ce(ce),
		.legBit(legBit), .legBitValid(legBitValid), .legBitReady(legBitReady),
		.pktData(pktData), .pktValid(pktValid), .pktLast(pktLast),
		.pktReady(pktReady), .symI(symI), .symQ(symQ), .symValid(symValid));
	otf_device otf_device_i (
		.link(otf_link_if_i), .clock(clock), .sys_rst(sys_rst), .ce(ce),
		.cfgMethod(cfgMethod), .cfgStrip(cfgStrip), .rxValid(rxValid),
		.rxData(rxData), .rxEnd(rxEnd), .rxBad(rxBad), .txI(txI),
		.txQ(txQ), .txValid(txValid), .txReady(txReady));
	otf_link_chk otf_link_chk_i (
		.sys_rst(sys_rst), .fwdClk(otf_link_if_i.fwdClk),
		.fwdData(otf_link_if_i.fwdData), .fwdValid(otf_link_if_i.fwdValid),
		.revClk(otf_link_if_i.revClk), .revI(otf_link_if_i.revI),
		.revQ(otf_link_if_i.revQ), .revEn(otf_link_if_i.revEn),
		.method(otf_link_if_i.method), .stripCount(otf_link_if_i.stripCount));
	// Gathers the module's user-side events in the core clock domain.
	always @(posedge clock) begin
		if (rxValid === 1'b1) begin
			rxQ.push_back(rxData);
		end
		if (rxEnd === 1'b1) begin
			endCnt++;
			lastBad = rxBad;
		end
	end
	// Records the wire itself, so framing is judged apart from the module.
	always @(posedge otf_link_if_i.fwdClk) begin
		if (otf_link_if_i.fwdValid === 1'b1) begin
			fwdBits.push_back(otf_link_if_i.fwdData);
		end
	end
	task automatic check(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clock);
		#2;
	endtask
	// Holds the request until its ready is high at the taking edge.
	task automatic take(input int which);
		for (int n = 0; n < 5000; n++) begin
			@(negedge clock);
			if ((which == 0 && pktReady === 1'b1) ||
				(which == 1 && legBitReady === 1'b1) ||
				(which == 2 && txReady === 1'b1)) begin
				@(posedge clock);
				#2;
				return;
			end
		end
		check("handshake", 16'h1, 16'h0);
	endtask
	// Sends one modem packet whose last four bytes stand for the CRC.
	task automatic run_tunnel(input int strip, input int n);
		int len;
		int e0;
		len = n - 4 - strip;
		cfgStrip = 8'(strip);
		settle(20);
		rxQ.delete();
		fwdBits.delete();
		e0 = endCnt;
		for (int i = 0; i < n; i++) begin
			pktData = 8'(8'h10 + i);
			pktValid = 1'b1;
			pktLast = (i == n - 1);
			take(0);
		end
		pktValid = 1'b0;
		pktLast = 1'b0;
		for (int k = 0; k < 3000 && endCnt == e0; k++) @(posedge clock);
		settle(10);
		if (len < 0) begin
			check("dropped packet bits", 16'h0, 16'(fwdBits.size()));
			check("dropped packet ends", 16'h0, 16'(endCnt - e0));
		end else begin
			check("frame ends", 16'h1, 16'(endCnt - e0));
			check("frame discard flag", 16'h0, 16'(lastBad));
			check("wire bits", 16'(16 + 8 * len), 16'(fwdBits.size()));
			w = 16'h0;
			for (int k = 0; k < 16; k++) w = {w[14:0], fwdBits[k]};
			check("length prefix", 16'(len), w);
			check("payload count", 16'(len), 16'(rxQ.size()));
			foreach (rxQ[k]) check("payload byte", 16'(8'h10 + strip + k), 16'(rxQ[k]));
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Cuts a hang short; the tests need well under a third of this span.
	initial begin
		#4000000;
		check("watchdog", 16'h0, 16'h1);
		report_and_stop();
	end
	// Main sequence: legacy methods both ways, then tunnel frames.
	initial begin
		#2 sys_rst = 1'b1;
		settle(4);
		sys_rst = 1'b0;
		settle(2);
		check("reset method", 16'(MTH_LEGACY_A), 16'(otf_link_if_i.method));
		check("reset strip", 16'h0, 16'(otf_link_if_i.stripCount));
		foreach (legM[j]) begin
			cfgMethod = legM[j];
			settle(20);
			check("legacy method", 16'(legM[j]), 16'(otf_link_if_i.method));
			rxQ.delete();
			w = 16'ha53c;
			for (int b = 15; b >= 0; b--) begin
				legBit = w[b];
				legBitValid = 1'b1;
				take(1);
			end
			legBitValid = 1'b0;
			settle(100);
			check("legacy bytes", 16'h2, 16'(rxQ.size()));
			check("legacy data", 16'ha53c, {rxQ[0], rxQ[1]});
			for (int s = 1; s < 3; s++) begin
				txI = s[1];
				txQ = s[0];
				txValid = 1'b1;
				take(2);
				txValid = 1'b0;
				for (int k = 0; k < 300; k++) begin
					@(posedge clock);
					if (symValid === 1'b1) break;
				end
				check("symbol", 16'(s), {14'h0, symI, symQ});
				settle(5);
			end
		end
		// A low enable must freeze the method although a new one waits.
		ce = 1'b0;
		cfgMethod = MTH_TUNNEL;
		settle(10);
		check("held method", 16'(legM[1]), 16'(otf_link_if_i.method));
		ce = 1'b1;
		settle(20);
		check("tunnel tx ready", 16'h0, 16'(txReady));
		for (int t = 0; t < 4; t++) run_tunnel(tStrip[t], tLen[t]);
		report_and_stop();
	end
endmodule // out_of_band_tunnel_frame_port_tb_top
`default_nettype wire
